// ### hdl/hpsc_pkg.sv
/*
 * hpsc_pkg: constants, field positions and carrier types for the hot-plug
 * slot control and status register bank of one downstream port.
 * Assumes a 32-bit APB slave port and one core clock with synchronous reset.
 */
package hpsc_pkg;

    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 32;
    localparam logic [11:0] SLOT_ADDR = 12'h0D8;

    // control field positions (low half of the word)
    localparam int CTL_ABE = 0;
    localparam int CTL_PFE = 1;
    localparam int CTL_PDE = 3;
    localparam int CTL_CCE = 4;
    localparam int CTL_HIE = 5;
    localparam int CTL_AI  = 6;
    localparam int CTL_PI  = 8;
    localparam int CTL_PWR = 10;
    localparam int CTL_DLE = 12;

    localparam logic [15:0] CTL_WMASK = 16'h17FB;
    localparam logic [15:0] CTL_RST   = 16'h03C0;

    // status field positions, relative to bit 16 of the word
    localparam int STAT_LSB = 16;
    localparam int ST_ABP   = 0;
    localparam int ST_PFD   = 1;
    localparam int ST_LSC   = 2;
    localparam int ST_PDC   = 3;
    localparam int ST_CC    = 4;
    localparam int ST_LS    = 5;
    localparam int ST_PDS   = 6;
    localparam int ST_DLC   = 8;

    localparam logic [15:0] ST_W1C    = 16'h011B;
    localparam logic [15:0] WAKE_MASK = 16'h010B;
    localparam logic [15:0] ST_RST    = 16'h0000;

    // cycles after reset before pin changes count as events
    localparam logic [2:0] SETTLE_CYC = 3'h5;

    typedef struct packed {
        logic cmdDone;
        logic presenceStrap;
        logic retentionLatch;
        logic powerFault;
        logic attnButton;
    } hpsc_pins_t;

    typedef struct packed {
        logic [1:0] attnInd;
        logic [1:0] pwrInd;
        logic       pwrOff;
        logic       attnMsg;
        logic       pwrMsg;
    } hpsc_slot_out_t;

endpackage : hpsc_pkg

// ### hdl/hpsc_slot_ctrl.sv
/*
 * hpsc_slot_ctrl: slot control and status word of a downstream port, with
 * pin synchronisers, sticky event flags, indicator and power control
 * outputs and the hot-plug interrupt and wake requests.
 * Assumes an APB master on clk, slot pins asynchronous to clk, and a
 * link-active level from the data link state machine on clk.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps

// three-stage synchroniser; output follows once stages two and three agree
module hpsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] flt_ff;
    logic [W-1:0] nxt_flt;

    // per-bit agreement filter
    assign nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
    assign dout    = flt_ff;

    // shift chain, reset to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            flt_ff <= '0;
        end else begin
            s1_ff  <= din;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end
endmodule : hpsc_sync

module hpsc_slot_ctrl
    import hpsc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire hpsc_pins_t        slotPins,
    input  wire logic              dlActive,
    input  wire logic              slotImpl,
    output hpsc_slot_out_t         slotOut,
    output logic                   hpIrq,
    output logic                   hpWake
);
    logic [15:0]       ctl_ff;
    logic [15:0]       nxt_ctl;
    logic [15:0]       flg_ff;
    logic [15:0]       nxt_flg;
    logic              pds_ff;
    logic              nxt_pds;
    logic              dlPrev_ff;
    logic [2:0]        settle_ff;
    logic [2:0]        nxt_settle;
    hpsc_pins_t        pinFlt;
    hpsc_pins_t        pinPrev_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic              irq_ff;
    logic              wake_ff;
    hpsc_slot_out_t    out_ff;
    hpsc_slot_out_t    nxt_out;

    logic              access;
    logic              rdLoad;
    logic              done;
    logic              hit;
    logic              wrDone;
    logic [15:0]       ctlMask;
    logic [15:0]       clrMask;
    logic [15:0]       setVec;
    logic [15:0]       statWord;
    logic [15:0]       enAlign;
    logic [15:0]       pendVec;
    logic              settled;
    logic              abPress;
    logic              pfRise;
    logic              latchChg;
    logic              cardNow;
    logic              presChg;
    logic              ccRise;
    logic              dlChg;
    logic              presRead;

    // pin synchronisers
    hpsc_sync #(
        .W ($bits(hpsc_pins_t))
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (slotPins),
        .dout (pinFlt)
    );

    // apb decode: one wait state, effects at the completing edge
    assign access  = psel & penable;
    assign rdLoad  = access & ~pready_ff;
    assign done    = access & pready_ff;
    assign hit     = (paddr == SLOT_ADDR);
    assign wrDone  = done & pwrite & hit;

    // byte-lane masks for control write and status clear
    assign ctlMask = CTL_WMASK & {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign clrMask = wrDone ? (ST_W1C & pwdata[31:16] & {{8{pstrb[3]}}, {8{pstrb[2]}}})
                            : 16'h0000;
    assign nxt_ctl = wrDone ? ((ctl_ff & ~ctlMask) | (pwdata[15:0] & ctlMask)) : ctl_ff;

    // pin events, held off until the synchronisers have filled
    assign settled  = (settle_ff == SETTLE_CYC);
    assign nxt_settle = settled ? settle_ff : settle_ff + 3'h1;
    assign abPress  = settled & pinFlt.attnButton & ~pinPrev_ff.attnButton;
    assign pfRise   = settled & pinFlt.powerFault & ~pinPrev_ff.powerFault;
    assign latchChg = settled & (pinFlt.retentionLatch ^ pinPrev_ff.retentionLatch);
    assign ccRise   = settled & pinFlt.cmdDone & ~pinPrev_ff.cmdDone;
    assign cardNow  = ~pinFlt.presenceStrap;
    assign presChg  = settled & slotImpl & (cardNow ^ pds_ff);
    assign nxt_pds  = presChg ? cardNow : pds_ff;
    assign dlChg    = dlActive ^ dlPrev_ff;

    // hardware set vector, aligned to status bits
    assign setVec = (16'(abPress)  << ST_ABP)
                  | (16'(pfRise)   << ST_PFD)
                  | (16'(latchChg) << ST_LSC)
                  | (16'(presChg)  << ST_PDC)
                  | (16'(ccRise)   << ST_CC)
                  | (16'(dlChg)    << ST_DLC);

    // set wins over a clear in the same cycle
    assign nxt_flg = (flg_ff & ~clrMask) | setVec;

    // status read view
    assign presRead = slotImpl ? pds_ff : 1'b1;
    assign statWord = flg_ff
                    | (16'(pinFlt.retentionLatch) << ST_LS)
                    | (16'(presRead) << ST_PDS);

    // enables aligned to their flags
    assign enAlign = (16'(ctl_ff[CTL_ABE]) << ST_ABP)
                   | (16'(ctl_ff[CTL_PFE]) << ST_PFD)
                   | (16'(ctl_ff[CTL_PDE]) << ST_PDC)
                   | (16'(ctl_ff[CTL_CCE]) << ST_CC)
                   | (16'(ctl_ff[CTL_DLE]) << ST_DLC);
    assign pendVec = flg_ff & enAlign;

    // slot-side controls and message strobes
    assign nxt_out = '{attnInd: nxt_ctl[CTL_AI +: 2],
                       pwrInd:  nxt_ctl[CTL_PI +: 2],
                       pwrOff:  nxt_ctl[CTL_PWR],
                       attnMsg: wrDone & pstrb[0],
                       pwrMsg:  wrDone & pstrb[1]};

    // register state
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_ff     <= CTL_RST;
            flg_ff     <= ST_RST;
            pds_ff     <= ~slotPins.presenceStrap;
            dlPrev_ff  <= 1'b0;
            settle_ff  <= 3'h0;
            pinPrev_ff <= '0;
        end else begin
            ctl_ff     <= nxt_ctl;
            flg_ff     <= nxt_flg;
            pds_ff     <= nxt_pds;
            dlPrev_ff  <= dlActive;
            settle_ff  <= nxt_settle;
            pinPrev_ff <= pinFlt;
        end
    end

    // apb answer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= rdLoad;
            pslverr_ff <= rdLoad & ~hit;
            prdata_ff  <= (rdLoad & hit) ? {statWord, ctl_ff} : 32'h0000_0000;
        end
    end

    // interrupt and wake requests
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq_ff  <= ctl_ff[CTL_HIE] & (|pendVec);
            wake_ff <= ~ctl_ff[CTL_HIE] & (|(pendVec & WAKE_MASK));
        end
    end

    // slot outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            out_ff <= '{attnInd: CTL_RST[CTL_AI +: 2], pwrInd: CTL_RST[CTL_PI +: 2],
                        pwrOff: 1'b0, attnMsg: 1'b0, pwrMsg: 1'b0};
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign hpIrq   = irq_ff;
    assign hpWake  = wake_ff;
    assign slotOut = out_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_READY: assert property (
        rdLoad |=> pready ##1 !pready)
        else $error("ready not given one cycle after access");

    AST_IRQ_GATE: assert property (
        !ctl_ff[CTL_HIE] |=> !hpIrq)
        else $error("interrupt raised while globally disabled");

    AST_IRQ_AB: assert property (
        ctl_ff[CTL_HIE] && ctl_ff[CTL_ABE] && flg_ff[ST_ABP] |=> hpIrq)
        else $error("button flag enabled but no interrupt");

    AST_IRQ_PF: assert property (
        ctl_ff[CTL_HIE] && ctl_ff[CTL_PFE] && flg_ff[ST_PFD] |=> hpIrq)
        else $error("fault flag enabled but no interrupt");

    AST_IRQ_PD: assert property (
        ctl_ff[CTL_HIE] && ctl_ff[CTL_PDE] && flg_ff[ST_PDC] |=> hpIrq)
        else $error("presence flag enabled but no interrupt");

    AST_IRQ_CC: assert property (
        ctl_ff[CTL_HIE] && ctl_ff[CTL_CCE] && flg_ff[ST_CC] |=> hpIrq)
        else $error("completion flag enabled but no interrupt");

    AST_IRQ_DL: assert property (
        ctl_ff[CTL_HIE] && ctl_ff[CTL_DLE] && flg_ff[ST_DLC] |=> hpIrq)
        else $error("link change flag enabled but no interrupt");

    AST_ATTN_MSG: assert property (
        wrDone && pstrb[0] |=> slotOut.attnMsg
            && slotOut.attnInd == $past(pwdata[CTL_AI +: 2]) ##1 !slotOut.attnMsg)
        else $error("attention write not mirrored with one message");

    AST_PWR_MSG: assert property (
        wrDone && pstrb[1] |=> slotOut.pwrMsg
            && slotOut.pwrInd == $past(pwdata[CTL_PI +: 2]))
        else $error("power indicator write not mirrored with message");

    AST_PWR_OFF: assert property (
        wrDone && pstrb[1] |=> slotOut.pwrOff == $past(pwdata[CTL_PWR]))
        else $error("power control not taken from write");

    AST_AB_SET: assert property (
        abPress |=> flg_ff[ST_ABP] && statWord[ST_ABP])
        else $error("button press not latched");

    AST_PF_SET: assert property (
        pfRise |=> flg_ff[ST_PFD])
        else $error("power fault not latched");

    AST_HOLD: assert property (
        flg_ff[ST_PDC] && !clrMask[ST_PDC] |=> flg_ff[ST_PDC])
        else $error("presence flag lost without clear");

    AST_SET_WINS: assert property (
        ccRise && clrMask[ST_CC] |=> flg_ff[ST_CC])
        else $error("completion lost to a same-cycle clear");

    AST_LSC_RO: assert property (
        flg_ff[ST_LSC] |=> flg_ff[ST_LSC])
        else $error("latch change flag cleared by software");

    AST_DL_CHG: assert property (
        (dlActive != dlPrev_ff) |=> flg_ff[ST_DLC])
        else $error("link active change not latched");

    AST_NOSLOT: assert property (
        rdLoad && hit && !slotImpl |=> prdata[STAT_LSB + ST_PDS])
        else $error("presence not reading 1 without slot");

    AST_LATCH_ST: assert property (
        rdLoad && hit |=> prdata[STAT_LSB + ST_LS] == $past(pinFlt.retentionLatch))
        else $error("latch state not reported");

    AST_W1C: assert property (
        flg_ff[ST_CC] && clrMask[ST_CC] && !ccRise |=> !flg_ff[ST_CC])
        else $error("completion flag did not clear on write 1");

endmodule : hpsc_slot_ctrl

// ### dv/hpsc_slot_model.sv
/*
 * hpsc_slot_model: behavioural slot seen from the port: button, power fault
 * sense, retention latch, card presence and a controller that answers each
 * indicator message with a command completion a few cycles long.
 * Assumes the bench drives the physical levels on clk rising edges.
 */
`timescale 1ns/1ps

module hpsc_slot_model
    import hpsc_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire hpsc_slot_out_t slotOut,
    input  wire logic           btnLvl,
    input  wire logic           faultLvl,
    input  wire logic           latchOpen,
    input  wire logic           cardIn,
    output hpsc_pins_t          slotPins
);
    logic [2:0] cmdCnt_ff;
    logic [2:0] nxt_cmdCnt;

    // done level lasts 4 cycles so the pin filter keeps it
    assign nxt_cmdCnt = (slotOut.attnMsg | slotOut.pwrMsg) ? 3'h4 :
                        (cmdCnt_ff != 3'h0) ? cmdCnt_ff - 3'h1 : 3'h0;

    // countdown of the command completion level
    always_ff @(posedge clk) begin
        if (rst) cmdCnt_ff <= 3'h0;
        else cmdCnt_ff <= nxt_cmdCnt;
    end

    // strap is high while the slot is empty
    assign slotPins = '{cmdDone: (cmdCnt_ff != 3'h0), presenceStrap: ~cardIn,
                        retentionLatch: latchOpen, powerFault: faultLvl,
                        attnButton: btnLvl};
endmodule : hpsc_slot_model

// ### dv/hot_plug_slot_control_status_tb_top.sv
/*
 * hot_plug_slot_control_status_tb_top: APB tests of the slot control and
 * status word with a slot model on the pins.
 * Assumes one 125 MHz clock and the one wait state answer of the slave.
 */
`timescale 1ns/1ps

module hot_plug_slot_control_status_tb_top;
    import hpsc_pkg::*;

    logic           clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic           dlActive, slotImpl, hpIrq, hpWake;
    logic           btnLvl, faultLvl, latchOpen, cardIn;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [3:0]     pstrb;
    logic [15:0]    ctlv;
    logic [1:0]     c;
    hpsc_pins_t     slotPins;
    hpsc_slot_out_t slotOut;
    int             num_errors = 0, n_checks = 0, attnCnt = 0, pwrCnt = 0, i;
    logic [15:0]    enBit [4] = '{16'h0001, 16'h0002, 16'h0008, 16'h1000};
    int             stBit [4] = '{16, 17, 19, 24};

    hpsc_slot_ctrl hpsc_slot_ctrl_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slotPins(slotPins), .dlActive(dlActive), .slotImpl(slotImpl),
        .slotOut(slotOut), .hpIrq(hpIrq), .hpWake(hpWake));

    hpsc_slot_model hpsc_slot_model_inst (.clk(clk), .rst(rst),
        .slotOut(slotOut), .btnLvl(btnLvl), .faultLvl(faultLvl),
        .latchOpen(latchOpen), .cardIn(cardIn), .slotPins(slotPins));

    // clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // count indicator message pulses
    always @(posedge clk) begin
        if (slotOut.attnMsg === 1'h1) attnCnt++;
        if (slotOut.pwrMsg === 1'h1) pwrCnt++;
    end

    task close_out;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one APB transfer; read data and error kept in rd and err
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                num_errors++;
                close_out();
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    // raise one kind of slot event
    task evt(input int k);
        case (k)
            0: begin
                btnLvl <= 1'h1;
                repeat (8) @(posedge clk);
                btnLvl <= 1'h0;
            end
            1: begin
                faultLvl <= 1'h1;
                repeat (8) @(posedge clk);
                faultLvl <= 1'h0;
            end
            2: cardIn <= ~cardIn;
            default: dlActive <= ~dlActive;
        endcase
        repeat (12) @(posedge clk);
    endtask : evt

    // watchdog
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // main sequence
    initial begin
        rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0; dlActive = 1'h0;
        slotImpl = 1'h1; btnLvl = 1'h0; faultLvl = 1'h0; latchOpen = 1'h0;
        cardIn = 1'h1;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk(rd, 32'h004003C0);
        chk({27'h0, slotOut.attnInd, slotOut.pwrInd, slotOut.pwrOff}, 32'h1E);
        for (i = 0; i < 4; i++) begin
            c = i[1:0];
            ctlv = {5'h0, c[0], ~c, c, 6'h0};
            apb(1'h1, SLOT_ADDR, {16'h0, ctlv}, 4'h3);
            chk({27'h0, slotOut.attnInd, slotOut.pwrInd, slotOut.pwrOff},
                {27'h0, c, ~c, c[0]});
            apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
            chk({16'h0, rd[15:0]}, {16'h0, ctlv});
        end
        chk(attnCnt, 4);
        chk(pwrCnt, 4);
        chk({31'h0, rd[20]}, 32'h1);
        chk({30'h0, hpIrq, hpWake}, 32'h0);
        apb(1'h1, SLOT_ADDR, 32'h03F0, 4'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, hpIrq}, 32'h1);
        apb(1'h1, SLOT_ADDR, 32'h03D0, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, hpIrq, hpWake}, 32'h0);
        repeat (8) @(posedge clk);
        apb(1'h1, SLOT_ADDR, 32'h00100000, 4'hC);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({31'h0, rd[20]}, 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'h1, SLOT_ADDR, {16'h0, 16'h03E0 | enBit[i]}, 4'h3);
            repeat (8) @(posedge clk);
            evt(i);
            chk({30'h0, hpIrq, hpWake}, 32'h2);
            apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
            chk({31'h0, rd[stBit[i]]}, 32'h1);
            apb(1'h1, SLOT_ADDR, 32'h1 << stBit[i], 4'hC);
            repeat (3) @(posedge clk);
            chk({31'h0, hpIrq}, 32'h0);
            apb(1'h1, SLOT_ADDR, {16'h0, 16'h03C0 | enBit[i]}, 4'h3);
            repeat (8) @(posedge clk);
            evt(i);
            chk({30'h0, hpIrq, hpWake}, 32'h1);
            apb(1'h1, SLOT_ADDR, 32'h1 << stBit[i], 4'hC);
        end
        latchOpen <= 1'h1;
        repeat (12) @(posedge clk);
        apb(1'h1, SLOT_ADDR, 32'h00040000, 4'hC);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({30'h0, rd[21], rd[18]}, 32'h3);
        apb(1'h1, 12'h0DC, 32'hFFFFFFFF, 4'hF);
        chk({31'h0, err}, 32'h1);
        apb(1'h0, 12'h0DC, 32'h0, 4'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({16'h0, rd[15:0]}, 32'h13C0);
        apb(1'h1, SLOT_ADDR, 32'h0000FFFF, 4'h3);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({16'h0, rd[15:0]}, 32'h17FB);
        slotImpl <= 1'h0;
        cardIn <= 1'h0;
        repeat (12) @(posedge clk);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({30'h0, rd[22], rd[19]}, 32'h2);
        // reset with no slot: presence state is 0 but must still read 1
        rst <= 1'h1;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk({31'h0, rd[22]}, 32'h1);
        slotImpl <= 1'h1;
        repeat (2) @(posedge clk);
        apb(1'h0, SLOT_ADDR, 32'h0, 4'h0);
        chk(rd, 32'h002003C0);
        close_out();
    end
endmodule : hot_plug_slot_control_status_tb_top
